// *** hdl/data_control_link.sv ***
// Interface joining the host-side controller and one drive controller.
// Resolves the shared wires from the drive enables; undriven lines read high.
`timescale 1ns/100ps
interface data_control_link;
  import dcl_pkg::*;
  // Control/status channel
  logic [CS_ADDR_W-1:0] ctl_stat_reg_addr;
  logic                 ctl_stat_read_strobe_n;
  logic                 ctl_stat_write_strobe_n;
  logic                 unitSel_n;
  logic [CS_DATA_W-1:0] hostCsData;
  logic                 hostCsOe;
  logic [CS_DATA_W-1:0] driveCsData;
  logic                 driveCsOe;
  logic [CS_DATA_W-1:0] ctl_stat_data;
  // Media data channel
  logic [MEDIA_W-1:0]   hostMediaData;
  logic                 hostMediaOe;
  logic [MEDIA_W-1:0]   driveMediaData;
  logic                 driveMediaOe;
  logic [MEDIA_W-1:0]   media_byte_bus;
  logic                 inReqVal_n;
  logic                 inReqOe;
  logic                 outReqVal_n;
  logic                 outReqOe;
  logic                 inbound_xfer_request_n;
  logic                 outbound_xfer_request_n;
  logic                 inbound_xfer_strobe_n;
  logic                 outbound_xfer_strobe_n;

  assign ctl_stat_data = driveCsOe ? driveCsData : (hostCsOe ? hostCsData : IDLE_BUS);
  assign media_byte_bus = driveMediaOe ? driveMediaData :
                          (hostMediaOe ? hostMediaData : IDLE_BUS);
  assign inbound_xfer_request_n  = inReqOe ? inReqVal_n : 1'b1;
  assign outbound_xfer_request_n = outReqOe ? outReqVal_n : 1'b1;

  modport host (
    output ctl_stat_reg_addr, ctl_stat_read_strobe_n, ctl_stat_write_strobe_n,
    output unitSel_n, hostCsData, hostCsOe, hostMediaData, hostMediaOe,
    output inbound_xfer_strobe_n, outbound_xfer_strobe_n,
    input  ctl_stat_data, media_byte_bus,
    input  inbound_xfer_request_n, outbound_xfer_request_n
  );
  modport drive (
    input  ctl_stat_reg_addr, ctl_stat_read_strobe_n, ctl_stat_write_strobe_n,
    input  unitSel_n, ctl_stat_data, media_byte_bus,
    input  inbound_xfer_strobe_n, outbound_xfer_strobe_n,
    output driveCsData, driveCsOe, driveMediaData, driveMediaOe,
    output inReqVal_n, inReqOe, outReqVal_n, outReqOe
  );
endinterface

// *** hdl/dcl_pkg.sv ***
// Shared constants and types for the data/control link between the
// host-side controller and a drive controller. Assumes one 100 MHz clock.
package dcl_pkg;
  localparam int CS_DATA_W = 8;
  localparam int CS_ADDR_W = 6;
  localparam int MEDIA_W   = 8;

  // Clock and slot timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLOT_TIME_US  = 500;
  localparam int SLOT_CYCLES   = SLOT_TIME_US * 1000 / CLK_PERIOD_NS;

  // Strobe shaping in clock cycles; phase counter width in bits
  localparam int CS_SETUP_CYC  = 1;
  localparam int STROBE_CYC    = 2;
  localparam int GAP_CYC       = 2;
  localparam int PHASE_W       = 2;

  // Drive controller register map
  localparam logic [CS_ADDR_W-1:0] CFG_ADDR    = 6'h00;
  localparam logic [CS_ADDR_W-1:0] STATUS_ADDR = 6'h01;
  localparam int CFG_OUT_EN_BIT = 0;
  localparam int CFG_IN_EN_BIT  = 1;
  localparam logic [CS_DATA_W-1:0] CFG_RESET = 8'h00;
  localparam logic [CS_DATA_W-1:0] IDLE_BUS  = 8'hFF;

  typedef enum logic [1:0] {SLOT_EXEC, SLOT_DRIVE0, SLOT_DRIVE1} slot_t;
endpackage

// *** hdl/drive_controller.sv ***
// Drive controller end of the data/control link: register file on the
// control/status channel, request/strobe byte exchange on the media channel.
// Assumes the host end shares the clock.
`timescale 1ns/100ps
module drive_controller
  import dcl_pkg::*;
#(
  parameter logic UNIT = 1'b0
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // Link
  data_control_link.drive           link,
  // Register writes seen by the drive logic
  output logic                      cmdValid,
  output logic [CS_ADDR_W-1:0]      cmdAddr,
  output logic [CS_DATA_W-1:0]      cmdData,
  // Bytes arriving from the host
  input  wire logic                 outWant,
  output logic                      outByteValid,
  output logic [MEDIA_W-1:0]        outByte,
  // Bytes going to the host
  input  wire logic                 inByteValid,
  input  wire logic [MEDIA_W-1:0]   inByteData,
  output logic                      inByteReady
);
  logic [CS_DATA_W-1:0] regs [2**CS_ADDR_W];
  logic [CS_DATA_W-1:0] cfg_q;
  logic [CS_DATA_W-1:0] rdData_q;
  logic                 wsPrev_q;
  logic                 isPrev_q;
  logic                 osPrev_q;
  logic                 inReq_q;
  logic                 outReq_q;
  logic [MEDIA_W-1:0]   inData_q;
  logic                 selected;
  logic                 wrEdge;
  logic                 inDone;
  logic                 outDone;

  assign selected = (link.unitSel_n == UNIT);
  assign wrEdge   = selected && wsPrev_q && !link.ctl_stat_write_strobe_n;
  assign inDone   = !isPrev_q && link.inbound_xfer_strobe_n;
  assign outDone  = !osPrev_q && link.outbound_xfer_strobe_n;

  always_ff @(posedge clock) begin
    if (reset) begin
      wsPrev_q <= 1'b1;
      isPrev_q <= 1'b1;
      osPrev_q <= 1'b1;
    end else begin
      wsPrev_q <= link.ctl_stat_write_strobe_n;
      isPrev_q <= link.inbound_xfer_strobe_n;
      osPrev_q <= link.outbound_xfer_strobe_n;
    end
  end

  // Register file; the config register gates the request lines
  always_ff @(posedge clock) begin
    if (wrEdge) begin
      regs[link.ctl_stat_reg_addr] <= link.ctl_stat_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_q <= CFG_RESET;
    end else if (wrEdge && link.ctl_stat_reg_addr == CFG_ADDR) begin
      cfg_q <= link.ctl_stat_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cmdValid <= 1'b0;
      cmdAddr  <= '0;
      cmdData  <= '0;
    end else begin
      cmdValid <= wrEdge;
      if (wrEdge) begin
        cmdAddr <= link.ctl_stat_reg_addr;
        cmdData <= link.ctl_stat_data;
      end
    end
  end

  // Config, status or register file byte; media bytes never pass here
  always_ff @(posedge clock) begin
    if (reset) begin
      rdData_q <= '0;
    end else if (link.ctl_stat_reg_addr == CFG_ADDR) begin
      rdData_q <= cfg_q;
    end else if (link.ctl_stat_reg_addr == STATUS_ADDR) begin
      rdData_q <= {6'h00, inReq_q, outReq_q};
    end else begin
      rdData_q <= regs[link.ctl_stat_reg_addr];
    end
  end

  assign link.driveCsData = rdData_q;
  assign link.driveCsOe   = selected && !link.ctl_stat_read_strobe_n;

  // One request, one strobe, per byte; released on the strobe's trailing edge
  always_ff @(posedge clock) begin
    if (reset) begin
      outReq_q <= 1'b0;
    end else if (outDone) begin
      outReq_q <= 1'b0;
    end else if (!cfg_q[CFG_OUT_EN_BIT]) begin
      // A pending request must not outlive the enable
      outReq_q <= 1'b0;
    end else if (outWant) begin
      outReq_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      inReq_q  <= 1'b0;
      inData_q <= '0;
    end else if (inDone) begin
      inReq_q <= 1'b0;
    end else if (!inReq_q && cfg_q[CFG_IN_EN_BIT] && inByteValid) begin
      inReq_q  <= 1'b1;
      inData_q <= inByteData;
    end
  end

  assign inByteReady = !reset && !inReq_q && !inDone && cfg_q[CFG_IN_EN_BIT];

  always_ff @(posedge clock) begin
    if (reset) begin
      outByteValid <= 1'b0;
      outByte      <= '0;
    end else begin
      outByteValid <= outDone && outReq_q;
      if (outDone) begin
        outByte <= link.media_byte_bus;
      end
    end
  end

  // Unselected or idle: request lines released
  assign link.outReqVal_n    = !outReq_q;
  assign link.outReqOe       = selected && outReq_q;
  assign link.inReqVal_n     = !inReq_q;
  assign link.inReqOe        = selected && inReq_q;
  assign link.driveMediaData = inData_q;
  assign link.driveMediaOe   = selected && inReq_q;
endmodule // drive_controller

// *** hdl/host_side_controller.sv ***
// Host-side controller end of the data/control link: control/status
// transfers, media byte strobing, buffer RAM sharing and slot timer.
// Assumes the drive end shares the clock and the bus wires are resolved
// by the interface.
`timescale 1ns/100ps
module host_side_controller
  import dcl_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES,
  parameter int TIMER_W  = 16,
  parameter int RAM_AW   = 11
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // Link
  data_control_link.host            link,
  // Control/status command port
  input  wire logic                 csReq,
  input  wire logic                 csWrite,
  input  wire logic                 csUnit,
  input  wire logic                 csBoth,
  input  wire logic [CS_ADDR_W-1:0] csAddr,
  input  wire logic [CS_DATA_W-1:0] csWrData,
  output logic                      csReady,
  output logic                      csDone,
  output logic [CS_DATA_W-1:0]      csRdData,
  // Media bytes toward the drive
  input  wire logic                 txValid,
  input  wire logic [MEDIA_W-1:0]   txData,
  output logic                      txReady,
  // Media bytes from the drive
  output logic                      rxValid,
  output logic [MEDIA_W-1:0]        rxData,
  // Processor side of the buffer RAM
  input  wire logic                 cpuEn,
  input  wire logic                 cpuWe,
  input  wire logic [RAM_AW-1:0]    cpuAddr,
  input  wire logic [MEDIA_W-1:0]   cpuWrData,
  output logic                      cpuAck,
  output logic [MEDIA_W-1:0]        cpuRdData,
  // DMA side of the buffer RAM
  input  wire logic                 dmaEn,
  input  wire logic                 dmaWe,
  input  wire logic [RAM_AW-1:0]    dmaAddr,
  input  wire logic [MEDIA_W-1:0]   dmaWrData,
  output logic                      dmaAck,
  output logic [MEDIA_W-1:0]        dmaRdData,
  // Slot timer and firmware bank
  input  wire logic                 timerWe,
  input  wire logic [TIMER_W-1:0]   timerWrData,
  output logic [TIMER_W-1:0]        timerValue,
  output slot_t                     activeSlot,
  output logic                      romBankSel
);
  initial begin
    if (SLOT_LEN < 1 || SLOT_LEN > 2**TIMER_W) begin
      $error("SLOT_LEN does not fit the timer width");
    end
  end

  typedef enum logic [1:0] {CS_IDLE, CS_SETUP, CS_STROBE} cs_state_t;
  typedef enum logic [1:0] {DX_IDLE, DX_OUT, DX_IN, DX_GAP} dx_state_t;

  localparam logic [TIMER_W-1:0] SLOT_LAST = TIMER_W'(SLOT_LEN - 1);

  cs_state_t            csState_q;
  logic [PHASE_W-1:0]   csCnt_q;
  logic                 csWr_q;
  logic                 csUnit_q;
  logic                 csSecond_q;
  logic [CS_ADDR_W-1:0] csAddr_q;
  logic [CS_DATA_W-1:0] csData_q;
  dx_state_t            dxState_q;
  logic [PHASE_W-1:0]   dxCnt_q;
  logic [MEDIA_W-1:0]   txData_q;
  logic                 dmaPhase_q;
  logic [MEDIA_W-1:0]   ram [2**RAM_AW];

  // Control/status sequencer
  assign csReady = (csState_q == CS_IDLE);

  always_ff @(posedge clock) begin
    if (reset) begin
      csState_q  <= CS_IDLE;
      csCnt_q    <= '0;
      csWr_q     <= 1'b0;
      csUnit_q   <= 1'b0;
      csSecond_q <= 1'b0;
      csAddr_q   <= '0;
      csData_q   <= '0;
    end else begin
      case (csState_q)
        CS_IDLE: begin
          if (csReq) begin
            csState_q  <= CS_SETUP;
            csCnt_q    <= '0;
            csWr_q     <= csWrite;
            csUnit_q   <= (csWrite && csBoth) ? 1'b0 : csUnit;
            csSecond_q <= csWrite && csBoth;
            csAddr_q   <= csAddr;
            csData_q   <= csWrData;
          end
        end
        CS_SETUP: begin
          csCnt_q <= csCnt_q + 1'b1;
          if (csCnt_q == PHASE_W'(CS_SETUP_CYC - 1)) begin
            csState_q <= CS_STROBE;
            csCnt_q   <= '0;
          end
        end
        CS_STROBE: begin
          csCnt_q <= csCnt_q + 1'b1;
          if (csCnt_q == PHASE_W'(STROBE_CYC - 1)) begin
            csCnt_q <= '0;
            if (csSecond_q) begin
              csSecond_q <= 1'b0;
              csUnit_q   <= 1'b1;
              csState_q  <= CS_SETUP;
            end else begin
              csState_q <= CS_IDLE;
            end
          end
        end
        default: csState_q <= CS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      csDone   <= 1'b0;
      csRdData <= '0;
    end else begin
      csDone <= (csState_q == CS_STROBE) && !csSecond_q &&
                (csCnt_q == PHASE_W'(STROBE_CYC - 1));
      if (csState_q == CS_STROBE && !csWr_q) begin
        csRdData <= link.ctl_stat_data;
      end
    end
  end

  assign link.ctl_stat_reg_addr       = csAddr_q;
  assign link.unitSel_n               = csUnit_q;
  assign link.hostCsData              = csData_q;
  assign link.hostCsOe                = csWr_q && (csState_q != CS_IDLE);
  assign link.ctl_stat_write_strobe_n = !(csWr_q && csState_q == CS_STROBE);
  assign link.ctl_stat_read_strobe_n  = !(!csWr_q && csState_q == CS_STROBE);

  // Media channel, independent of the control/status sequencer
  assign txReady = (dxState_q == DX_IDLE) && link.inbound_xfer_request_n &&
                   !link.outbound_xfer_request_n;

  always_ff @(posedge clock) begin
    if (reset) begin
      dxState_q <= DX_IDLE;
      dxCnt_q   <= '0;
      txData_q  <= '0;
    end else begin
      case (dxState_q)
        DX_IDLE: begin
          dxCnt_q <= '0;
          if (!link.inbound_xfer_request_n) begin
            dxState_q <= DX_IN;
          end else if (txReady && txValid) begin
            dxState_q <= DX_OUT;
            txData_q  <= txData;
          end
        end
        DX_OUT, DX_IN: begin
          dxCnt_q <= dxCnt_q + 1'b1;
          if (dxCnt_q == PHASE_W'(STROBE_CYC - 1)) begin
            dxState_q <= DX_GAP;
            dxCnt_q   <= '0;
          end
        end
        DX_GAP: begin
          // Lets the drive drop its request before the next look
          dxCnt_q <= dxCnt_q + 1'b1;
          if (dxCnt_q == PHASE_W'(GAP_CYC - 1)) begin
            dxState_q <= DX_IDLE;
          end
        end
        default: dxState_q <= DX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rxValid <= 1'b0;
      rxData  <= '0;
    end else begin
      rxValid <= (dxState_q == DX_IN) && (dxCnt_q == PHASE_W'(STROBE_CYC - 1));
      if (dxState_q == DX_IN) begin
        rxData <= link.media_byte_bus;
      end
    end
  end

  logic outDriving_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      outDriving_q <= 1'b0;
    end else if (dxState_q == DX_IDLE) begin
      outDriving_q <= txReady && txValid;
    end
  end

  assign link.hostMediaData          = txData_q;
  assign link.hostMediaOe            = outDriving_q && (dxState_q != DX_IDLE);
  assign link.outbound_xfer_strobe_n = !(dxState_q == DX_OUT);
  assign link.inbound_xfer_strobe_n  = !(dxState_q == DX_IN);

  // Buffer RAM: even cycle processor, odd cycle DMA
  always_ff @(posedge clock) begin
    if (reset) begin
      dmaPhase_q <= 1'b0;
    end else begin
      dmaPhase_q <= !dmaPhase_q;
    end
  end

  assign cpuAck = cpuEn && !dmaPhase_q;
  assign dmaAck = dmaEn && dmaPhase_q;

  always_ff @(posedge clock) begin
    if (cpuAck && cpuWe) begin
      ram[cpuAddr] <= cpuWrData;
    end else if (dmaAck && dmaWe) begin
      ram[dmaAddr] <= dmaWrData;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cpuRdData <= '0;
      dmaRdData <= '0;
    end else begin
      if (cpuAck) begin
        cpuRdData <= ram[cpuAddr];
      end
      if (dmaAck) begin
        dmaRdData <= ram[dmaAddr];
      end
    end
  end

  // Slot timer; a processor write loads timerWrData into the current slot's count
  always_ff @(posedge clock) begin
    if (reset) begin
      timerValue <= '0;
      activeSlot <= SLOT_EXEC;
    end else if (timerWe) begin
      timerValue <= timerWrData;
    end else if (timerValue >= SLOT_LAST) begin
      timerValue <= '0;
      case (activeSlot)
        SLOT_EXEC:   activeSlot <= SLOT_DRIVE0;
        SLOT_DRIVE0: activeSlot <= SLOT_DRIVE1;
        default:     activeSlot <= SLOT_EXEC;
      endcase
    end else begin
      timerValue <= timerValue + 1'b1;
    end
  end

  // Bank holds through the exec slot
  always_ff @(posedge clock) begin
    if (reset) begin
      romBankSel <= 1'b0;
    end else if (activeSlot == SLOT_DRIVE0) begin
      romBankSel <= 1'b0;
    end else if (activeSlot == SLOT_DRIVE1) begin
      romBankSel <= 1'b1;
    end
  end
endmodule // host_side_controller

// *** sim/dcl_link_sva.sv ***
// Checker for the wires of the data/control link.
// Assumes it is instantiated beside the link interface and sees its wires only.
`timescale 1ns/100ps
module dcl_link_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control/status channel
  input wire logic ctl_stat_read_strobe_n,
  input wire logic ctl_stat_write_strobe_n,
  input wire logic unitSel_n,
  input wire logic hostCsOe,
  input wire logic driveCsOe,
  // Media channel
  input wire logic hostMediaOe,
  input wire logic inbound_xfer_request_n,
  input wire logic outbound_xfer_request_n,
  input wire logic inbound_xfer_strobe_n,
  input wire logic outbound_xfer_strobe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  wr_strobe_width_a: assert property ($fell(ctl_stat_write_strobe_n) |->
    !ctl_stat_write_strobe_n ##1 !ctl_stat_write_strobe_n ##1 ctl_stat_write_strobe_n)
    else $error("Write strobe width wrong");
  rd_strobe_width_a: assert property ($fell(ctl_stat_read_strobe_n) |->
    !ctl_stat_read_strobe_n [*2] ##1 ctl_stat_read_strobe_n)
    else $error("Read strobe width wrong");
  rd_drive_owns_a: assert property (!ctl_stat_read_strobe_n && !unitSel_n |->
    driveCsOe && !hostCsOe)
    else $error("Status byte not driven by drive end");
  wr_host_owns_a: assert property (!ctl_stat_write_strobe_n |->
    hostCsOe && !driveCsOe)
    else $error("Command byte not driven by host end");
  cs_one_strobe_a: assert property (
    ctl_stat_read_strobe_n || ctl_stat_write_strobe_n)
    else $error("Both control strobes low");
  out_strobe_width_a: assert property ($fell(outbound_xfer_strobe_n) |->
    !outbound_xfer_strobe_n [*2] ##1 outbound_xfer_strobe_n)
    else $error("Outbound strobe width wrong");
  in_strobe_width_a: assert property ($fell(inbound_xfer_strobe_n) |->
    !inbound_xfer_strobe_n ##1 !inbound_xfer_strobe_n ##1 inbound_xfer_strobe_n)
    else $error("Inbound strobe width wrong");
  out_host_drives_a: assert property (!outbound_xfer_strobe_n |-> hostMediaOe)
    else $error("Outbound byte not driven by host end");
  out_answers_req_a: assert property ($fell(outbound_xfer_strobe_n) |->
    !outbound_xfer_request_n)
    else $error("Outbound strobe without request");
  in_answers_req_a: assert property ($fell(inbound_xfer_strobe_n) |->
    !inbound_xfer_request_n && !hostMediaOe)
    else $error("Inbound strobe without request");
  out_req_release_a: assert property ($rose(outbound_xfer_strobe_n) |=>
    outbound_xfer_request_n)
    else $error("Outbound request held after strobe");
  one_direction_a: assert property (
    inbound_xfer_strobe_n || outbound_xfer_strobe_n)
    else $error("Both data strobes low");
endmodule // dcl_link_sva

// *** sim/testbench.sv ***
// Self-checking bench: host end and drive end joined by the link interface.
// Assumes one 100 MHz clock; the slot length is cut to 8 cycles.
`timescale 1ns/100ps
module testbench;
  import dcl_pkg::*;
  localparam int SL = 8;
  logic                 clock, reset, csReq, csWrite, csUnit, csBoth, csReady, csDone;
  logic                 txValid, txReady, rxValid, outWant, outByteValid, inByteValid;
  logic                 inByteReady, cpuEn, cpuWe, cpuAck, dmaEn, dmaWe, dmaAck;
  logic                 timerWe, romBankSel, cmdValid;
  logic [CS_ADDR_W-1:0] csAddr, cmdAddr;
  logic [7:0]           csWrData, csRdData, txData, rxData, outByte, inByteData, cmdData;
  logic [7:0]           cpuWrData, cpuRdData, dmaWrData, dmaRdData;
  logic [10:0]          cpuAddr, dmaAddr;
  logic [15:0]          timerWrData, timerValue;
  slot_t                activeSlot;
  int                   n_fail, total_checks;

  data_control_link link();
  host_side_controller #(.SLOT_LEN(SL)) i_host_side_controller (.clock, .reset, .link,
    .csReq, .csWrite, .csUnit, .csBoth, .csAddr, .csWrData, .csReady, .csDone, .csRdData,
    .txValid, .txData, .txReady, .rxValid, .rxData, .cpuEn, .cpuWe, .cpuAddr, .cpuWrData,
    .cpuAck, .cpuRdData, .dmaEn, .dmaWe, .dmaAddr, .dmaWrData, .dmaAck, .dmaRdData,
    .timerWe, .timerWrData, .timerValue, .activeSlot, .romBankSel);
  drive_controller #(.UNIT(1'b0)) i_drive_controller (.clock, .reset, .link, .cmdValid,
    .cmdAddr, .cmdData, .outWant, .outByteValid, .outByte, .inByteValid, .inByteData,
    .inByteReady);
  dcl_link_sva i_dcl_link_sva (.clock, .reset,
    .ctl_stat_read_strobe_n(link.ctl_stat_read_strobe_n),
    .ctl_stat_write_strobe_n(link.ctl_stat_write_strobe_n),
    .unitSel_n(link.unitSel_n), .hostCsOe(link.hostCsOe), .driveCsOe(link.driveCsOe),
    .hostMediaOe(link.hostMediaOe),
    .inbound_xfer_request_n(link.inbound_xfer_request_n),
    .outbound_xfer_request_n(link.outbound_xfer_request_n),
    .inbound_xfer_strobe_n(link.inbound_xfer_strobe_n),
    .outbound_xfer_strobe_n(link.outbound_xfer_strobe_n));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check16({8'h00, got}, {8'h00, exp});
  endtask

  // Bounded wait, sampled mid-cycle so edge updates have landed
  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    @(negedge clock);
    while (s !== 1'b1 && k < 40) begin
      @(negedge clock);
      k++;
    end
    check8({7'h00, s}, 8'h01);
  endtask

  task automatic cs_op(input logic wr, u, both, input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    csReq <= 1'b1;
    csWrite <= wr;
    csUnit <= u;
    csBoth <= both;
    csAddr <= a;
    csWrData <= d;
    wait_hi(csReady);
    @(posedge clock);
    csReq <= 1'b0;
    wait_hi(csDone);
  endtask

  task automatic tx_byte(input logic [7:0] d);
    @(posedge clock);
    txValid <= 1'b1;
    txData <= d;
    wait_hi(txReady);
    @(posedge clock);
    txValid <= 1'b0;
    wait_hi(outByteValid);
  endtask

  task automatic rx_byte(input logic [7:0] d);
    @(posedge clock);
    inByteValid <= 1'b1;
    inByteData <= d;
    wait_hi(inByteReady);
    @(posedge clock);
    inByteValid <= 1'b0;
    wait_hi(rxValid);
  endtask

  task automatic ram_op(input logic dma, we, input logic [10:0] a, input logic [7:0] d);
    @(posedge clock);
    dmaEn <= dma;
    dmaWe <= we;
    dmaAddr <= a;
    dmaWrData <= d;
    cpuEn <= !dma;
    cpuWe <= we;
    cpuAddr <= a;
    cpuWrData <= d;
    if (dma) wait_hi(dmaAck);
    else wait_hi(cpuAck);
    @(posedge clock);
    cpuEn <= 1'b0;
    dmaEn <= 1'b0;
    @(negedge clock);
  endtask

  // Load the timer two short of the wrap, then expect the next slot
  task automatic slot_step(input slot_t exp, input logic bank);
    @(posedge clock);
    timerWe <= 1'b1;
    timerWrData <= 16'(SL - 2);
    @(posedge clock);
    timerWe <= 1'b0;
    @(negedge clock);
    check16(timerValue, 16'(SL - 2));
    repeat (2) @(posedge clock);
    @(negedge clock);
    check16(16'(activeSlot), 16'(exp));
    @(negedge clock);
    check8({7'h00, romBankSel}, {7'h00, bank});
  endtask

  initial begin
    {csReq, csWrite, csUnit, csBoth, txValid, outWant, inByteValid} = '0;
    {cpuEn, cpuWe, dmaEn, dmaWe, timerWe, csAddr, csWrData, txData, inByteData} = '0;
    {cpuAddr, dmaAddr, cpuWrData, dmaWrData, timerWrData} = '0;
    {n_fail, total_checks} = '0;
    reset = 1'b1;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    // Timer first, while the slot is still known from reset
    slot_step(SLOT_DRIVE0, 1'b0);
    slot_step(SLOT_DRIVE1, 1'b1);
    slot_step(SLOT_EXEC, 1'b1);
    $display("Test slot_timer done");
    @(posedge clock);
    outWant <= 1'b1;
    cs_op(1'b0, 1'b0, 1'b0, STATUS_ADDR, 8'h00);
    check8(csRdData, 8'h00);
    check8({7'h00, txReady}, 8'h00);
    cs_op(1'b1, 1'b0, 1'b0, CFG_ADDR, 8'h01);
    cs_op(1'b0, 1'b0, 1'b0, STATUS_ADDR, 8'h00);
    check8(csRdData, 8'h01);
    foreach (txData[i]) begin
      tx_byte(8'h81 << i);
      check8(outByte, 8'h81 << i);
    end
    $display("Test outbound done");
    @(posedge clock);
    outWant <= 1'b0;
    cs_op(1'b1, 1'b0, 1'b0, CFG_ADDR, 8'h02);
    for (int i = 0; i < 3; i++) begin
      rx_byte(8'h5A ^ 8'(i * 8'h33));
      check8(rxData, 8'h5A ^ 8'(i * 8'h33));
    end
    $display("Test inbound done");
    for (int i = 0; i < 2; i++) begin
      cs_op(1'b1, 1'b0, 1'b0, i ? 6'h3F : 6'h2A, 8'hC3 ^ 8'(i));
      check8(cmdData, 8'hC3 ^ 8'(i));
      check8({2'b00, cmdAddr}, {2'b00, (i ? 6'h3F : 6'h2A)});
      cs_op(1'b0, 1'b0, 1'b0, i ? 6'h3F : 6'h2A, 8'h00);
      check8(csRdData, 8'hC3 ^ 8'(i));
    end
    cs_op(1'b1, 1'b0, 1'b0, 6'h05, 8'h77);
    cs_op(1'b1, 1'b1, 1'b0, 6'h05, 8'h11);
    cs_op(1'b0, 1'b0, 1'b0, 6'h05, 8'h00);
    check8(csRdData, 8'h77);
    cs_op(1'b0, 1'b1, 1'b0, 6'h05, 8'h00);
    check8(csRdData, IDLE_BUS);
    cs_op(1'b1, 1'b0, 1'b1, 6'h06, 8'h3C);
    cs_op(1'b0, 1'b0, 1'b0, 6'h06, 8'h00);
    check8(csRdData, 8'h3C);
    $display("Test control_status done");
    ram_op(1'b0, 1'b1, 11'h005, 8'h5A);
    ram_op(1'b1, 1'b0, 11'h005, 8'h00);
    check8(dmaRdData, 8'h5A);
    ram_op(1'b1, 1'b1, 11'h7FF, 8'hC3);
    ram_op(1'b0, 1'b0, 11'h7FF, 8'h00);
    check8(cpuRdData, 8'hC3);
    @(posedge clock);
    cpuEn <= 1'b1;
    dmaEn <= 1'b1;
    cpuWe <= 1'b0;
    dmaWe <= 1'b0;
    repeat (4) begin
      @(negedge clock);
      check8({7'h00, cpuAck}, {7'h00, ~dmaAck});
    end
    @(posedge clock);
    cpuEn <= 1'b0;
    dmaEn <= 1'b0;
    $display("Test buffer_ram done");
    tally_and_finish();
  end

  // Whole run needs a few hundred cycles; 20000 means a hang
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
endmodule // testbench
